// ==== rtl/dsmc_defines.svh ====
// offsets, bit positions, codes and counts for the drive state machine control block
`ifndef DSMC_DEFINES_SVH
`define DSMC_DEFINES_SVH

`define DSMC_CTRL_WORD_OFFSET   16'h6040
`define DSMC_STAT_WORD_OFFSET   16'h6041
`define DSMC_CTRL_RESET         16'h0000

`define DSMC_CW_SWITCH_ON       0
`define DSMC_CW_ENABLE_VOLTAGE  1
`define DSMC_CW_QUICK_STOP      2
`define DSMC_CW_ENABLE_OP       3
`define DSMC_CW_FAULT_RESET     7
`define DSMC_CW_HALT            8

`define DSMC_SW_READY           0
`define DSMC_SW_SWITCHED_ON     1
`define DSMC_SW_OP_ENABLED      2
`define DSMC_SW_FAULT           3
`define DSMC_SW_VOLTAGE         4
`define DSMC_SW_QUICK_STOP      5
`define DSMC_SW_SWON_DISABLED   6
`define DSMC_SW_REMOTE          9

`define DSMC_SRC_NETWORK        2'h1
`define DSMC_INIT_CYCLES        16
`define DSMC_REACT_CYCLES       4

`endif

// ==== rtl/dsmc_pkg.sv ====
// types shared by the drive state machine control files
package dsmc_pkg;

    typedef enum logic [2:0] {
        DSMC_NOT_READY   = 3'b000,
        DSMC_SWON_DIS    = 3'b001,
        DSMC_READY       = 3'b010,
        DSMC_SWITCHED_ON = 3'b011,
        DSMC_OP_ENABLED  = 3'b100,
        DSMC_QUICK_STOP  = 3'b101,
        DSMC_FAULT_REACT = 3'b110,
        DSMC_FAULT       = 3'b111
    } dsmc_state_t;

    typedef enum logic [2:0] {
        DSMC_CMD_NONE      = 3'b000,
        DSMC_CMD_SHUTDOWN  = 3'b001,
        DSMC_CMD_SWITCH_ON = 3'b010,
        DSMC_CMD_DIS_VOLT  = 3'b011,
        DSMC_CMD_QSTOP     = 3'b100,
        DSMC_CMD_ENABLE_OP = 3'b101,
        DSMC_CMD_FAULT_RST = 3'b110
    } dsmc_cmd_t;

endpackage : dsmc_pkg

// ==== rtl/dsmc_cmd_decode.sv ====
// control word command decoder with fault reset edge detect
`timescale 1ns/10ps
`include "dsmc_defines.svh"

module dsmc_cmd_decode (
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic [15:0]       ctrl_word,
    output dsmc_pkg::dsmc_cmd_t    cmd
);

    logic fault_reset_prev_q;
    logic fr;
    logic ev;
    logic qs;
    logic so;
    logic eo;

    assign fr = ctrl_word[`DSMC_CW_FAULT_RESET];
    assign ev = ctrl_word[`DSMC_CW_ENABLE_VOLTAGE];
    assign qs = ctrl_word[`DSMC_CW_QUICK_STOP];
    assign so = ctrl_word[`DSMC_CW_SWITCH_ON];
    assign eo = ctrl_word[`DSMC_CW_ENABLE_OP];

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            fault_reset_prev_q <= 1'b0;
        end else begin
            fault_reset_prev_q <= fr;
        end
    end

    // bits 4-6, 8 and 9-15 never reach the decode
    always_comb begin
        cmd = dsmc_pkg::DSMC_CMD_NONE;
        if (fr && !fault_reset_prev_q) begin
            cmd = dsmc_pkg::DSMC_CMD_FAULT_RST;
        end else if (!fr && !ev) begin
            cmd = dsmc_pkg::DSMC_CMD_DIS_VOLT;
        end else if (!fr && !qs) begin
            cmd = dsmc_pkg::DSMC_CMD_QSTOP;
        end else if (!fr && !so) begin
            cmd = dsmc_pkg::DSMC_CMD_SHUTDOWN;
        end else if (!fr && !eo) begin
            cmd = dsmc_pkg::DSMC_CMD_SWITCH_ON;
        end else if (!fr) begin
            cmd = dsmc_pkg::DSMC_CMD_ENABLE_OP;
        end
    end

    a_fr_edge_wins : assert property (@(posedge ref_clk) disable iff (!rst_n)
        (fr && !$past(fr)) |-> cmd == dsmc_pkg::DSMC_CMD_FAULT_RST)
        else $error("fault reset edge not decoded");
    a_dv_decode : assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!fr && !ev) |-> cmd == dsmc_pkg::DSMC_CMD_DIS_VOLT)
        else $error("disable voltage not decoded");
    a_qs_decode : assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!fr && ev && !qs) |-> cmd == dsmc_pkg::DSMC_CMD_QSTOP)
        else $error("quick stop not decoded");

endmodule : dsmc_cmd_decode

// ==== rtl/dsmc_drive_ctrl.sv ====
// drive device control state machine with control and status words
`timescale 1ns/10ps
`include "dsmc_defines.svh"

module dsmc_drive_ctrl #(
    parameter int INIT_CYCLES  = `DSMC_INIT_CYCLES,
    parameter int REACT_CYCLES = `DSMC_REACT_CYCLES
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] obj_addr,
    input  wire logic        obj_wr,
    input  wire logic [15:0] obj_wdata,
    output logic      [15:0] obj_rdata,
    output logic             obj_err,
    input  wire logic [1:0]  control_source_select_param,
    input  wire logic        fault_in,
    output logic             drive_enable,
    output logic             ramp_stop,
    output logic             ramp_start,
    output logic             voltage_enabled,
    output logic      [15:0] control_word_backing_param,
    output logic      [15:0] status_word
);

    // ---------------------------------------------------------------
    // input synchronisers
    // ---------------------------------------------------------------
    logic fault_meta_q;
    logic fault_sync_q;
    logic [1:0] src_meta_q;
    logic [1:0] src_sync_q;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            fault_meta_q <= 1'b0;
            fault_sync_q <= 1'b0;
            src_meta_q   <= 2'h0;
            src_sync_q   <= 2'h0;
        end else begin
            fault_meta_q <= fault_in;
            fault_sync_q <= fault_meta_q;
            src_meta_q   <= control_source_select_param;
            src_sync_q   <= src_meta_q;
        end
    end

    // ---------------------------------------------------------------
    // control word object
    // ---------------------------------------------------------------
    logic [15:0] ctrl_word_q;
    logic        remote;

    assign remote = (src_sync_q == `DSMC_SRC_NETWORK);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl_word_q <= `DSMC_CTRL_RESET;
        end else if (obj_wr && obj_addr == `DSMC_CTRL_WORD_OFFSET) begin
            ctrl_word_q <= obj_wdata;
        end
    end

    assign control_word_backing_param = ctrl_word_q;

    // status word is read-only: writes to it are refused with obj_err
    always_comb begin
        obj_rdata = 16'h0000;
        obj_err   = 1'b0;
        if (obj_addr == `DSMC_CTRL_WORD_OFFSET) begin
            obj_rdata = ctrl_word_q;
        end else if (obj_addr == `DSMC_STAT_WORD_OFFSET) begin
            obj_rdata = status_word;
            obj_err   = obj_wr;
        end else begin
            obj_err   = obj_wr;
        end
    end

    // ---------------------------------------------------------------
    // command decode
    // ---------------------------------------------------------------
    dsmc_pkg::dsmc_cmd_t cmd_raw;
    dsmc_pkg::dsmc_cmd_t cmd;

    dsmc_cmd_decode u_decode (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .ctrl_word (ctrl_word_q),
        .cmd       (cmd_raw)
    );

    assign cmd = remote ? cmd_raw : dsmc_pkg::DSMC_CMD_NONE;

    // ---------------------------------------------------------------
    // timers
    // ---------------------------------------------------------------
    dsmc_pkg::dsmc_state_t state_q;
    dsmc_pkg::dsmc_state_t state_d;
    logic [15:0] init_cnt_q;
    logic [15:0] react_cnt_q;
    logic        init_done;
    logic        react_done;

    assign init_done  = (init_cnt_q  == 16'(INIT_CYCLES - 1));
    assign react_done = (react_cnt_q == 16'(REACT_CYCLES - 1));

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            init_cnt_q <= 16'h0000;
        end else if (state_q == dsmc_pkg::DSMC_NOT_READY && !init_done) begin
            init_cnt_q <= init_cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            react_cnt_q <= 16'h0000;
        end else if (state_q == dsmc_pkg::DSMC_FAULT_REACT) begin
            react_cnt_q <= react_done ? react_cnt_q : react_cnt_q + 16'h0001;
        end else begin
            react_cnt_q <= 16'h0000;
        end
    end

    // ---------------------------------------------------------------
    // state machine
    // ---------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            dsmc_pkg::DSMC_NOT_READY: begin
                if (init_done) begin
                    state_d = dsmc_pkg::DSMC_SWON_DIS;
                end
            end
            dsmc_pkg::DSMC_SWON_DIS: begin
                if (cmd == dsmc_pkg::DSMC_CMD_SHUTDOWN) begin
                    state_d = dsmc_pkg::DSMC_READY;
                end
            end
            dsmc_pkg::DSMC_READY: begin
                if (cmd == dsmc_pkg::DSMC_CMD_SWITCH_ON) begin
                    state_d = dsmc_pkg::DSMC_SWITCHED_ON;
                end else if (cmd == dsmc_pkg::DSMC_CMD_DIS_VOLT ||
                             cmd == dsmc_pkg::DSMC_CMD_QSTOP) begin
                    state_d = dsmc_pkg::DSMC_SWON_DIS;
                end
            end
            dsmc_pkg::DSMC_SWITCHED_ON: begin
                if (cmd == dsmc_pkg::DSMC_CMD_ENABLE_OP) begin
                    state_d = dsmc_pkg::DSMC_OP_ENABLED;
                end else if (cmd == dsmc_pkg::DSMC_CMD_SHUTDOWN) begin
                    state_d = dsmc_pkg::DSMC_READY;
                end else if (cmd == dsmc_pkg::DSMC_CMD_DIS_VOLT ||
                             cmd == dsmc_pkg::DSMC_CMD_QSTOP) begin
                    state_d = dsmc_pkg::DSMC_SWON_DIS;
                end
            end
            dsmc_pkg::DSMC_OP_ENABLED: begin
                if (cmd == dsmc_pkg::DSMC_CMD_SWITCH_ON) begin
                    state_d = dsmc_pkg::DSMC_SWITCHED_ON;
                end else if (cmd == dsmc_pkg::DSMC_CMD_SHUTDOWN) begin
                    state_d = dsmc_pkg::DSMC_READY;
                end else if (cmd == dsmc_pkg::DSMC_CMD_DIS_VOLT) begin
                    state_d = dsmc_pkg::DSMC_SWON_DIS;
                end else if (cmd == dsmc_pkg::DSMC_CMD_QSTOP) begin
                    state_d = dsmc_pkg::DSMC_QUICK_STOP;
                end
            end
            dsmc_pkg::DSMC_QUICK_STOP: begin
                if (cmd == dsmc_pkg::DSMC_CMD_ENABLE_OP) begin
                    state_d = dsmc_pkg::DSMC_OP_ENABLED;
                end else if (cmd == dsmc_pkg::DSMC_CMD_DIS_VOLT) begin
                    state_d = dsmc_pkg::DSMC_SWON_DIS;
                end
            end
            dsmc_pkg::DSMC_FAULT_REACT: begin
                if (react_done) begin
                    state_d = dsmc_pkg::DSMC_FAULT;
                end
            end
            dsmc_pkg::DSMC_FAULT: begin
                if (cmd == dsmc_pkg::DSMC_CMD_FAULT_RST) begin
                    state_d = dsmc_pkg::DSMC_SWON_DIS;
                end
            end
            default: begin
                state_d = dsmc_pkg::DSMC_NOT_READY;
            end
        endcase
        // fault entry overrides everything except an active fault path
        if (fault_sync_q && state_q != dsmc_pkg::DSMC_FAULT_REACT &&
            state_q != dsmc_pkg::DSMC_FAULT) begin
            state_d = dsmc_pkg::DSMC_FAULT_REACT;
        end
        // other command/state pairs fall through with no change
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q <= dsmc_pkg::DSMC_NOT_READY;
        end else begin
            state_q <= state_d;
        end
    end

    // ---------------------------------------------------------------
    // power stage outputs
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            drive_enable <= 1'b0;
            ramp_stop    <= 1'b0;
            ramp_start   <= 1'b0;
        end else begin
            drive_enable <= (state_d == dsmc_pkg::DSMC_OP_ENABLED) ||
                            (state_d == dsmc_pkg::DSMC_QUICK_STOP);
            ramp_stop    <= (state_d == dsmc_pkg::DSMC_QUICK_STOP);
            ramp_start   <= (state_q == dsmc_pkg::DSMC_QUICK_STOP) &&
                            (state_d == dsmc_pkg::DSMC_OP_ENABLED);
        end
    end

    // supply has no switch; it is live from power-up onward
    assign voltage_enabled = 1'b1;

    // ---------------------------------------------------------------
    // status word
    // ---------------------------------------------------------------
    always_comb begin
        status_word = 16'h0000;
        status_word[`DSMC_SW_VOLTAGE] = voltage_enabled;
        status_word[`DSMC_SW_REMOTE]  = remote;
        case (state_q)
            dsmc_pkg::DSMC_SWON_DIS:    status_word[6:0] = {1'b1, 1'b0, 1'b1, 4'h0};
            dsmc_pkg::DSMC_READY:       status_word[6:0] = {1'b0, 1'b1, 1'b1, 4'h1};
            dsmc_pkg::DSMC_SWITCHED_ON: status_word[6:0] = {1'b0, 1'b1, 1'b1, 4'h3};
            dsmc_pkg::DSMC_OP_ENABLED:  status_word[6:0] = {1'b0, 1'b1, 1'b1, 4'h7};
            dsmc_pkg::DSMC_QUICK_STOP:  status_word[6:0] = {1'b0, 1'b0, 1'b1, 4'h7};
            dsmc_pkg::DSMC_FAULT_REACT: status_word[6:0] = {1'b0, 1'b0, 1'b1, 4'hF};
            dsmc_pkg::DSMC_FAULT:       status_word[6:0] = {1'b0, 1'b0, 1'b1, 4'h8};
            default:                    status_word[6:0] = {1'b0, 1'b0, 1'b1, 4'h0};
        endcase
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sequence s_react_entry;
        state_q != dsmc_pkg::DSMC_FAULT_REACT ##1 state_q == dsmc_pkg::DSMC_FAULT_REACT;
    endsequence

    a_init_ignores_cmd : assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_q == dsmc_pkg::DSMC_NOT_READY && !init_done && !fault_sync_q)
        |=> state_q == dsmc_pkg::DSMC_NOT_READY)
        else $error("left not ready before init done");
    a_init_auto_exit : assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_q == dsmc_pkg::DSMC_NOT_READY && init_done && !fault_sync_q)
        |=> state_q == dsmc_pkg::DSMC_SWON_DIS)
        else $error("init done without switch-on disabled");
    a_shutdown_ready : assert property (@(posedge ref_clk) disable iff (!rst_n)
        (cmd == dsmc_pkg::DSMC_CMD_SHUTDOWN && !fault_sync_q &&
         (state_q == dsmc_pkg::DSMC_SWON_DIS || state_q == dsmc_pkg::DSMC_OP_ENABLED))
        |=> state_q == dsmc_pkg::DSMC_READY && !drive_enable)
        else $error("shutdown did not reach ready");
    a_enable_drive : assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_q == dsmc_pkg::DSMC_SWITCHED_ON && cmd == dsmc_pkg::DSMC_CMD_ENABLE_OP && !fault_sync_q)
        |=> state_q == dsmc_pkg::DSMC_OP_ENABLED && drive_enable)
        else $error("enable operation failed");
    a_qstop_ramp : assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_q == dsmc_pkg::DSMC_OP_ENABLED && cmd == dsmc_pkg::DSMC_CMD_QSTOP && !fault_sync_q)
        |=> ramp_stop && drive_enable)
        else $error("quick stop without ramp");
    a_fault_react_path : assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_react_entry |-> !drive_enable ##REACT_CYCLES state_q == dsmc_pkg::DSMC_FAULT)
        else $error("fault reaction path wrong");
    a_fault_no_power : assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_q == dsmc_pkg::DSMC_FAULT |-> !drive_enable)
        else $error("drive enabled in fault");
    a_local_ignored : assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!remote && !fault_sync_q && state_q != dsmc_pkg::DSMC_NOT_READY &&
         state_q != dsmc_pkg::DSMC_FAULT_REACT) |=> $stable(state_q))
        else $error("command acted in local control");
    a_status_code : assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_q == dsmc_pkg::DSMC_OP_ENABLED |-> status_word[6:0] == 7'b0110111)
        else $error("status word mismatch");

endmodule : dsmc_drive_ctrl

// ==== verification/dsmc_master_model.sv ====
// network master model issuing control object writes and reads
`timescale 1ns/10ps

module dsmc_master_model (
    input  wire logic        ref_clk,
    output logic      [15:0] obj_addr,
    output logic             obj_wr,
    output logic      [15:0] obj_wdata,
    input  wire logic [15:0] obj_rdata,
    input  wire logic        obj_err
);
    initial begin
        obj_addr  = 16'h0000;
        obj_wr    = 1'b0;
        obj_wdata = 16'h0000;
    end

    // one write held across one sampling edge
    task automatic write_obj(input logic [15:0] addr, input logic [15:0] data, output logic err);
        @(negedge ref_clk);
        obj_addr  = addr;
        obj_wdata = data;
        obj_wr    = 1'b1;
        #1 err = obj_err;
        @(negedge ref_clk);
        obj_wr    = 1'b0;
        obj_wdata = ~data;
    endtask : write_obj

    task automatic read_obj(input logic [15:0] addr, output logic [15:0] data);
        @(negedge ref_clk);
        obj_addr = addr;
        #1 data = obj_rdata;
    endtask : read_obj
endmodule : dsmc_master_model

// ==== verification/drive_state_machine_ctrl_tb_top.sv ====
// self-checking bench for the drive state machine control block
`timescale 1ns/10ps
`include "dsmc_defines.svh"

module drive_state_machine_ctrl_tb_top;
    localparam int INIT_N  = 2;
    localparam int REACT_N = 2;
    localparam logic [15:0] WALK [18] = '{16'h0176, 16'hfe07, 16'h000f, 16'h0002, 16'h017f, 16'h0007,
        16'h000f, 16'h0006, 16'h000f, 16'h0002, 16'h0006, 16'hfe07, 16'h0000, 16'h0006, 16'h0007,
        16'h000f, 16'h0072, 16'h0001};
    logic        ref_clk, rst_n, fault_in, obj_wr, obj_err, drive_enable, ramp_stop, ramp_start;
    logic        voltage_enabled, remote, err, seen;
    logic [15:0] obj_addr, obj_wdata, obj_rdata, control_word_backing_param, status_word, last_w, rd, w;
    logic [13:0] mv;
    logic [1:0]  src_sel;
    int          failures, check_count;
    dsmc_pkg::dsmc_state_t exp_st;

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    dsmc_drive_ctrl #(.INIT_CYCLES(INIT_N), .REACT_CYCLES(REACT_N)) dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .obj_addr(obj_addr), .obj_wr(obj_wr), .obj_wdata(obj_wdata),
        .obj_rdata(obj_rdata), .obj_err(obj_err), .control_source_select_param(src_sel),
        .fault_in(fault_in), .drive_enable(drive_enable), .ramp_stop(ramp_stop), .ramp_start(ramp_start),
        .voltage_enabled(voltage_enabled), .control_word_backing_param(control_word_backing_param),
        .status_word(status_word));

    dsmc_master_model m_master (.ref_clk(ref_clk), .obj_addr(obj_addr), .obj_wr(obj_wr),
        .obj_wdata(obj_wdata), .obj_rdata(obj_rdata), .obj_err(obj_err));

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim

    // mask and value of the state bits 6..0
    function automatic logic [13:0] stat_exp(input dsmc_pkg::dsmc_state_t s);
        case (s)
            dsmc_pkg::DSMC_NOT_READY:   return {7'h4f, 7'h00};
            dsmc_pkg::DSMC_SWON_DIS:    return {7'h4f, 7'h40};
            dsmc_pkg::DSMC_READY:       return {7'h6f, 7'h21};
            dsmc_pkg::DSMC_SWITCHED_ON: return {7'h6f, 7'h23};
            dsmc_pkg::DSMC_OP_ENABLED:  return {7'h6f, 7'h27};
            dsmc_pkg::DSMC_QUICK_STOP:  return {7'h6f, 7'h07};
            dsmc_pkg::DSMC_FAULT_REACT: return {7'h4f, 7'h0f};
            default:                    return {7'h4f, 7'h08};
        endcase
    endfunction : stat_exp

    function automatic dsmc_pkg::dsmc_state_t nxt(input dsmc_pkg::dsmc_state_t s, input logic [15:0] cw,
                                                   input logic rise);
        logic dv, qs, sd, so, eo;
        dv = !cw[7] && !cw[1];
        qs = !cw[7] && !cw[2] && cw[1];
        sd = !cw[7] && cw[2:0] == 3'b110;
        so = !cw[7] && cw[3:0] == 4'b0111;
        eo = !cw[7] && cw[3:0] == 4'b1111;
        if (!remote) return s;
        case (s)
            dsmc_pkg::DSMC_FAULT:       return rise ? dsmc_pkg::DSMC_SWON_DIS : s;
            dsmc_pkg::DSMC_SWON_DIS:    return sd ? dsmc_pkg::DSMC_READY : s;
            dsmc_pkg::DSMC_READY:       return (dv || qs) ? dsmc_pkg::DSMC_SWON_DIS :
                                               so ? dsmc_pkg::DSMC_SWITCHED_ON : s;
            dsmc_pkg::DSMC_SWITCHED_ON: return (dv || qs) ? dsmc_pkg::DSMC_SWON_DIS : sd ? dsmc_pkg::DSMC_READY :
                                               eo ? dsmc_pkg::DSMC_OP_ENABLED : s;
            dsmc_pkg::DSMC_OP_ENABLED:  return dv ? dsmc_pkg::DSMC_SWON_DIS : qs ? dsmc_pkg::DSMC_QUICK_STOP :
                                               sd ? dsmc_pkg::DSMC_READY : so ? dsmc_pkg::DSMC_SWITCHED_ON : s;
            dsmc_pkg::DSMC_QUICK_STOP:  return dv ? dsmc_pkg::DSMC_SWON_DIS : eo ? dsmc_pkg::DSMC_OP_ENABLED : s;
            default:                    return s;
        endcase
    endfunction : nxt

    task automatic check_state(input string what);
        logic [13:0] m;
        m = stat_exp(exp_st);
        check({what, " status"}, {9'h000, m[6:0]}, {9'h000, status_word[6:0] & m[13:7]});
        check({what, " remote"}, {14'h0000, remote, 1'b1}, {14'h0000, status_word[9], status_word[4]});
        check({what, " drive"}, {14'h0000, exp_st inside {dsmc_pkg::DSMC_OP_ENABLED, dsmc_pkg::DSMC_QUICK_STOP},
              exp_st == dsmc_pkg::DSMC_QUICK_STOP}, {14'h0000, drive_enable, ramp_stop});
        check({what, " supply"}, 16'h0001, {15'h0000, voltage_enabled});
    endtask : check_state

    task automatic cmd(input logic [15:0] cw);
        int pulses;
        logic restart;
        restart = exp_st == dsmc_pkg::DSMC_QUICK_STOP;
        exp_st = nxt(exp_st, cw, !last_w[7] && cw[7]);
        restart = restart && exp_st == dsmc_pkg::DSMC_OP_ENABLED;
        last_w = cw;
        m_master.write_obj(16'h6040, cw, err);
        check("write flag", 16'h0000, {15'h0000, err});
        pulses = 0;
        repeat (4) begin
            @(negedge ref_clk);
            pulses += int'(ramp_start === 1'b1);
        end
        check("ramp start", {15'h0000, restart}, 16'(pulses));
        check("backing", cw, control_word_backing_param);
        check_state("cmd");
    endtask : cmd

    initial begin
        #(40 * 20000);
        failures++;
        $display("watchdog expired");
        end_sim();
    end

    initial begin
        failures = 0;
        check_count = 0;
        rst_n = 1'b0;
        fault_in = 1'b0;
        src_sel = `DSMC_SRC_NETWORK;
        remote = 1'b1;
        last_w = 16'h0000;
        exp_st = dsmc_pkg::DSMC_NOT_READY;
        void'($urandom(32'hb01e_be04));
        repeat (8) @(negedge ref_clk);
        check("reset status", 16'h0010, status_word);
        rst_n = 1'b1;
        @(negedge ref_clk);
        check("not ready", 16'h0000, {9'h000, status_word[6:0] & 7'h4f});
        repeat (INIT_N + 3) @(negedge ref_clk);
        exp_st = dsmc_pkg::DSMC_SWON_DIS;
        check_state("init");
        m_master.read_obj(16'h6040, rd);
        check("ctrl reset", `DSMC_CTRL_RESET, rd);
        $display("test reset done");
        foreach (WALK[i]) cmd(WALK[i]);
        $display("test walk done");
        m_master.write_obj(16'h6041, 16'h0006, err);
        check("ro write flag", 16'h0001, {15'h0000, err});
        m_master.write_obj(16'h1234, 16'h0006, err);
        check("unmapped flag", 16'h0001, {15'h0000, err});
        m_master.read_obj(16'h1234, rd);
        check("unmapped read", 16'h0000, rd);
        m_master.read_obj(16'h6041, rd);
        mv = stat_exp(exp_st);
        check("status obj", {9'h000, mv[6:0]}, {9'h000, rd[6:0] & mv[13:7]});
        m_master.read_obj(16'h6040, rd);
        check("ctrl kept", last_w, rd);
        repeat (3) @(negedge ref_clk);
        check_state("objects");
        $display("test objects done");
        src_sel = 2'h0;
        remote = 1'b0;
        repeat (4) @(negedge ref_clk);
        cmd(16'h0006);
        cmd(16'h0000);
        src_sel = `DSMC_SRC_NETWORK;
        remote = 1'b1;
        repeat (4) @(negedge ref_clk);
        $display("test source done");
        cmd(16'h0006);
        cmd(16'h0007);
        cmd(16'h000f);
        fault_in = 1'b1;
        seen = 1'b0;
        repeat (10) begin
            @(negedge ref_clk);
            if (!seen && status_word[3:0] === 4'hf) begin
                seen = 1'b1;
                exp_st = dsmc_pkg::DSMC_FAULT_REACT;
                check_state("react");
            end
        end
        check("react seen", 16'h0001, {15'h0000, seen});
        exp_st = dsmc_pkg::DSMC_FAULT;
        check_state("fault");
        fault_in = 1'b0;
        repeat (4) @(negedge ref_clk);
        cmd(16'h0006);
        cmd(16'h008f);
        cmd(16'h000f);
        $display("test fault done");
        repeat (150) begin
            w = 16'($urandom);
            if (w[15]) w[7] = 1'b0;
            cmd(w);
        end
        $display("test random done");
        end_sim();
    end
endmodule : drive_state_machine_ctrl_tb_top
